// ---- rtl/machine_check_interrupt_control.sv ----
// Machine check gating: decides take, defer, hold or check stop per condition.
// Assumes one-cycle event pulses from error detectors on hclk and an AHB-Lite master.
//
// Operation
// - Cooling fault sets warning bit 6.
// - Program exception check sets cause bit 3.
// - Repeat program exception under mask requests check.
// - Snapshots 7 and 8 keep exception details.
// - Masked repressible condition stays pending, no logout.
// - Subclass mask bits reset to zero.
// - Control bit 0 is check stop control.
// - Bit 2 gates ordinary system recovery.
// - Bit 3 gates external damage except tabler.
// - Bit 5 gates single-bit correction reports.
// - Bit 6 gates degradation, bit 7 caches.
// - Warning and exigent conditions ignore subclass masks.
// - Taken interrupt stores cause code to logout.
// - Check mask sets on accept, clears on load.
// - Exception mask sets on accept, clears on load.
// - Exigent: interrupt, check stop, or defer.
// - Deferred exigent taken after load, delayed flag.
// - Repressible needs both hardware masks clear.
// - Conditions during repressible interrupt share cause code.
// - Taking repressible reports and releases other deferred.
// - Mask set on deferred triggers; no delay flag.
// - Same handling in wait, execute, step.
// - System damage flags cause bit 0.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "mck_regs.svh"
module machine_check_interrupt_control
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [11:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire mck_pkg::mck_events_t    events,
  input  wire mck_pkg::prog_exc_info_t prog_exc_info,
  input  wire logic                    exc_accept,
  input  wire logic                    exc_load_done,
  input  wire logic                    check_load_done,
  input  wire logic                    check_accept,
  output logic                         check_request,
  output logic                         prog_interrupt_request,
  output logic                         check_stop,
  output logic [63:0]                  check_cause_code,
  output logic                         logout_store
);
  import mck_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave.
  logic        wr_pend_q;
  logic [11:0] addr_q;
  logic [31:0] subclass_q;
  logic        rd_take;
  logic        wr_take;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_take   = hsel && hready && htrans[1] && hwrite;
  assign rd_take   = hsel && hready && htrans[1] && !hwrite;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end
    else
    begin
      wr_pend_q <= wr_take;
      if (hsel && hready && htrans[1])
        addr_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      subclass_q <= `MCK_SUBCLASS_RST;
    else if (wr_pend_q && addr_q == `MCK_SUBCLASS_OFS)
      subclass_q <= hwdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Masks and state.
  mck_state_t  state_q;
  logic        check_hw_mask_q;
  logic        prog_exc_hw_mask_q;
  logic [31:0] snap7_q;
  logic [31:0] snap8_q;
  logic [31:0] snap7_addr_q;

  logic cs_ctl;
  logic recovery_class_mask;
  logic outside_damage_mask;
  logic single_bit_fix_mask;
  logic degrade_class_mask;
  logic cache_class_mask;
  assign cs_ctl              = subclass_q[`MCK_CS_BIT];
  assign recovery_class_mask = subclass_q[`MCK_RM_BIT];
  assign outside_damage_mask = subclass_q[`MCK_EM_BIT];
  assign single_bit_fix_mask = subclass_q[`MCK_SM_BIT];
  assign degrade_class_mask  = subclass_q[`MCK_DM_BIT];
  assign cache_class_mask    = subclass_q[`MCK_XM_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Pending repressible conditions, one sticky bit each.
  localparam int NREP = 7;
  logic [NREP-1:0] rep_set;
  logic [NREP-1:0] rep_pend;
  logic [NREP-1:0] rep_enable;
  logic            rep_release;
  logic            exi_set;
  logic            exi_pend;
  logic            exi_release;

  // Index: 0 recovery, 1 single-bit, 2 cache, 3 outside, 4 tabler, 5 degrade, 6 warning.
  assign rep_set[0] = events.recovery_class && !events.single_bit_fix_flag &&
                      !(events.operand_cache_fault || events.instr_cache_fault ||
                        events.microcode_accel_fault);
  assign rep_set[1] = events.recovery_class && events.single_bit_fix_flag;
  assign rep_set[2] = events.recovery_class && (events.operand_cache_fault ||
                      events.instr_cache_fault || events.microcode_accel_fault);
  assign rep_set[3] = events.outside_damage_class && !events.io_status_tabler_fault;
  assign rep_set[4] = events.outside_damage_class && events.io_status_tabler_fault;
  assign rep_set[5] = events.degrade_class;
  assign rep_set[6] = events.cooling_abnormal;

  assign rep_enable[0] = recovery_class_mask;
  assign rep_enable[1] = single_bit_fix_mask;
  assign rep_enable[2] = cache_class_mask;
  assign rep_enable[3] = outside_damage_mask;
  assign rep_enable[4] = 1'b1;
  assign rep_enable[5] = degrade_class_mask;
  assign rep_enable[6] = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < NREP; gi++)
    begin : g_rep
      mck_sticky u_rep
      (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .set         (rep_set[gi]),
        .release_now (rep_release && rep_enable[gi]),
        .pending     (rep_pend[gi])
      );
    end
  endgenerate

  assign exi_set = (events.whole_system_fault_class || events.instr_fault_class ||
                    events.exigent_degrade) && check_hw_mask_q && !cs_ctl;
  mck_sticky u_exi
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .set         (exi_set),
    .release_now (exi_release),
    .pending     (exi_pend)
  );

  // Kind of the held exigent and cache conditions, kept so that the cause code can name it when it is taken.
  logic [2:0] exi_kind_q;
  logic [1:0] cache_kind_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      exi_kind_q <= 3'b000;
    else if (exi_set)
      exi_kind_q <= exi_kind_q | {events.whole_system_fault_class, events.instr_fault_class,
                                  events.exigent_degrade};
    else if (exi_release)
      exi_kind_q <= 3'b000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cache_kind_q <= 2'b00;
    else if (rep_set[2])
      cache_kind_q <= cache_kind_q | {events.operand_cache_fault,
                                      events.instr_cache_fault || events.microcode_accel_fault};
    else if (rep_release && rep_enable[2])
      cache_kind_q <= 2'b00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gating decisions; processor run state does not enter them.
  logic exigent_now;
  logic exigent_take;
  logic deferred_take;
  logic rep_ready;
  logic rep_take;
  logic pex_take;
  logic take_any;

  assign exigent_now   = events.whole_system_fault_class || events.instr_fault_class ||
                         events.exigent_degrade;
  assign exigent_take  = exigent_now && !check_hw_mask_q && state_q == ST_RUN;
  assign deferred_take = exi_pend && !check_hw_mask_q && state_q == ST_RUN;
  assign rep_ready     = |(rep_pend & rep_enable);
  assign rep_take      = rep_ready && !check_hw_mask_q && !prog_exc_hw_mask_q &&
                         state_q == ST_RUN;
  assign pex_take      = events.program_exception && prog_exc_hw_mask_q &&
                         !check_hw_mask_q && state_q == ST_RUN;
  assign take_any      = exigent_take || deferred_take || rep_take || pex_take;
  assign rep_release   = take_any;
  assign exi_release   = deferred_take;

  assign prog_interrupt_request = events.program_exception && !prog_exc_hw_mask_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Cause code assembly and interrupt sequencing.
  logic [63:0] cause_q;
  logic [63:0] cause_d;

  always_comb
  begin
    cause_d = 64'h0;
    cause_d[`MCK_CC_SD]  = events.whole_system_fault_class ||
                           (deferred_take && exi_kind_q[2]);
    cause_d[`MCK_CC_PD]  = events.instr_fault_class || (deferred_take && exi_kind_q[1]);
    cause_d[`MCK_CC_DG]  = events.exigent_degrade || (deferred_take && exi_kind_q[0]) ||
                           (rep_pend[5] && rep_enable[5]);
    cause_d[`MCK_CC_SR]  = |(rep_pend[2:0] & rep_enable[2:0]);
    cause_d[`MCK_CC_SC]  = rep_pend[1] && rep_enable[1];
    cause_d[`MCK_CC_ED]  = |(rep_pend[4:3] & rep_enable[4:3]);
    cause_d[`MCK_CC_IO_STATUS_TABLER_FAULT] = rep_pend[4];
    cause_d[`MCK_CC_W]   = rep_pend[6];
    cause_d[`MCK_CC_OCE] = rep_pend[2] && rep_enable[2] && cache_kind_q[1];
    cause_d[`MCK_CC_ICE] = rep_pend[2] && rep_enable[2] && cache_kind_q[0];
    cause_d[`MCK_CC_PEX] = pex_take;
    cause_d[`MCK_CC_D]   = deferred_take && !exigent_take;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= ST_RUN;
    else if (exigent_now && check_hw_mask_q && cs_ctl)
      state_q <= ST_STOP;
    else if (events.program_exception && check_hw_mask_q && prog_exc_hw_mask_q)
      state_q <= ST_STOP;
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          if (take_any)
            state_q <= ST_INIT;
        end
        ST_INIT:
        begin
          if (check_accept)
            state_q <= ST_HANDLER;
        end
        ST_HANDLER:
        begin
          if (check_load_done)
            state_q <= ST_RUN;
        end
        ST_STOP:
          state_q <= ST_STOP;
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cause_q <= 64'h0;
    else if (state_q == ST_RUN && take_any)
      cause_q <= cause_d;
    else if (state_q == ST_INIT)
      cause_q <= cause_q | cause_d;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      check_hw_mask_q <= 1'b0;
    else if (state_q == ST_INIT && check_accept)
      check_hw_mask_q <= 1'b1;
    else if (check_load_done)
      check_hw_mask_q <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prog_exc_hw_mask_q <= 1'b0;
    else if (exc_accept)
      prog_exc_hw_mask_q <= 1'b1;
    else if (exc_load_done)
      prog_exc_hw_mask_q <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      snap7_q      <= 32'h0;
      snap7_addr_q <= 32'h0;
      snap8_q      <= 32'h0;
    end
    else if (pex_take)
    begin
      snap7_q      <= prog_exc_info.final_code;
      snap7_addr_q <= prog_exc_info.final_addr;
      snap8_q      <= prog_exc_info.second_cause;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      logout_store <= 1'b0;
    else
      logout_store <= state_q == ST_INIT && check_accept;
  end

  assign check_request    = state_q == ST_INIT;
  assign check_stop       = state_q == ST_STOP;
  assign check_cause_code = cause_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (rd_take)
    begin
      case (haddr)
        `MCK_SUBCLASS_OFS: hrdata <= subclass_q;
        `MCK_STATUS_OFS:   hrdata <= {21'h0, exi_pend, rep_pend, check_stop,
                                      prog_exc_hw_mask_q, check_hw_mask_q};
        `MCK_CAUSE_LO_OFS: hrdata <= cause_q[31:0];
        `MCK_CAUSE_HI_OFS: hrdata <= cause_q[63:32];
        `MCK_SNAP7_OFS:    hrdata <= snap7_q ^ snap7_addr_q;
        `MCK_SNAP8_OFS:    hrdata <= snap8_q;
        default:           hrdata <= 32'h0;
      endcase
    end
  end
endmodule

// ---- rtl/mck_pkg.sv ----
// Types shared by the check gating block.
// Assumes the register header is included by the files that need numbers.
package mck_pkg;
  typedef struct packed {
    logic whole_system_fault_class;
    logic instr_fault_class;
    logic exigent_degrade;
    logic recovery_class;
    logic single_bit_fix_flag;
    logic operand_cache_fault;
    logic instr_cache_fault;
    logic microcode_accel_fault;
    logic outside_damage_class;
    logic io_status_tabler_fault;
    logic degrade_class;
    logic cooling_abnormal;
    logic program_exception;
  } mck_events_t;
  typedef struct packed {
    logic [31:0] final_code;
    logic [31:0] final_addr;
    logic [31:0] second_cause;
  } prog_exc_info_t;
  typedef enum logic [1:0] {ST_RUN, ST_INIT, ST_HANDLER, ST_STOP} mck_state_t;
endpackage

// ---- rtl/mck_regs.svh ----
// Register offsets, field positions and reset values for the check gating block.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
`ifndef MCK_REGS_SVH
`define MCK_REGS_SVH
`define MCK_SUBCLASS_OFS   12'h000
`define MCK_STATUS_OFS     12'h004
`define MCK_CAUSE_LO_OFS   12'h008
`define MCK_CAUSE_HI_OFS   12'h00c
`define MCK_SNAP7_OFS      12'h010
`define MCK_SNAP8_OFS      12'h014
`define MCK_SUBCLASS_RST   32'h0000_0000
`define MCK_CS_BIT         0
`define MCK_RM_BIT         2
`define MCK_EM_BIT         3
`define MCK_SM_BIT         5
`define MCK_DM_BIT         6
`define MCK_XM_BIT         7
`define MCK_CC_SD          0
`define MCK_CC_PD          1
`define MCK_CC_SR          2
`define MCK_CC_PEX         3
`define MCK_CC_ED          4
`define MCK_CC_W           6
`define MCK_CC_DG          5
`define MCK_CC_B           7
`define MCK_CC_D           8
`define MCK_CC_SC          10
`define MCK_CC_MAE         14
`define MCK_CC_ICE         14
`define MCK_CC_OCE         15
`define MCK_CC_IO_STATUS_TABLER_FAULT        22
`endif

// ---- rtl/mck_sticky.sv ----
// One pending condition bit: a set in the same cycle as a release wins.
// Assumes set and release come from logic on hclk.
`timescale 1ns/100ps
module mck_sticky
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set,
  input  wire logic release_now,
  output logic      pending
);
  logic pending_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pending_q <= 1'b0;
    else if (set)
      pending_q <= 1'b1;
    else if (release_now)
      pending_q <= 1'b0;
  end
  assign pending = pending_q;
endmodule

// ---- testbench/machine_check_interrupt_control_assertions.sv ----
// Concurrent checks on the ports of the machine check gating block.
// Assumes one clock hclk and the asynchronous active-low reset hresetn.
`timescale 1ns/100ps
`include "mck_regs.svh"
module machine_check_interrupt_control_checker
(
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire mck_pkg::mck_events_t events,
  input wire logic                 exc_accept,
  input wire logic                 exc_load_done,
  input wire logic                 check_accept,
  input wire logic                 check_load_done,
  input wire logic                 check_request,
  input wire logic                 prog_interrupt_request,
  input wire logic                 check_stop,
  input wire logic [63:0]          check_cause_code,
  input wire logic                 logout_store
);
  import mck_pkg::*;
  logic mc_q;
  logic px_q;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Hardware masks as seen from the handshake pulses.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mc_q <= 1'b0;
    else if (check_accept)
      mc_q <= 1'b1;
    else if (check_load_done)
      mc_q <= 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      px_q <= 1'b0;
    else if (exc_accept)
      px_q <= 1'b1;
    else if (exc_load_done)
      px_q <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_free;
    !mc_q && !check_request && !check_stop;
  endsequence
  sequence s_raised(int b);
    check_request && check_cause_code[b];
  endsequence
  a_warn_taken: assert property (s_free ##0 (events.cooling_abnormal && !px_q)
    |-> ##2 s_raised(`MCK_CC_W)) else $error("warning not raised");
  a_damage_taken: assert property (s_free ##0 events.whole_system_fault_class
    |=> s_raised(`MCK_CC_SD)) else $error("system damage not raised");
  a_prog_direct: assert property (events.program_exception && !px_q
    |-> prog_interrupt_request) else $error("program interrupt missing");
  a_prog_check: assert property (
    s_free ##0 (events.program_exception && px_q && !exc_load_done)
    |-> !prog_interrupt_request ##1 s_raised(`MCK_CC_PEX)) else $error("no exception check");
  a_req_holds: assert property (check_request && !check_accept
    |=> check_request || check_stop) else $error("request dropped early");
  a_logout_pulse: assert property (check_request && check_accept
    |=> logout_store ##1 !logout_store) else $error("logout pulse wrong");
  a_stop_holds: assert property (check_stop |=> check_stop)
    else $error("check stop released");
  a_mask_blocks: assert property (mc_q |-> !check_request)
    else $error("request under check mask");
endmodule
bind machine_check_interrupt_control machine_check_interrupt_control_checker chk_u
(
  .hclk(hclk), .hresetn(hresetn), .events(events), .exc_accept(exc_accept),
  .exc_load_done(exc_load_done), .check_accept(check_accept),
  .check_load_done(check_load_done), .check_request(check_request),
  .prog_interrupt_request(prog_interrupt_request), .check_stop(check_stop),
  .check_cause_code(check_cause_code), .logout_store(logout_store)
);

// ---- testbench/machine_check_interrupt_control_tb_top.sv ----
// Self-checking bench for the machine check gating block.
// Assumes the handler model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`include "mck_regs.svh"
module machine_check_interrupt_control_tb_top;
  import mck_pkg::*;
  logic           hclk = 1'b0;
  logic           hresetn = 1'b0;
  logic           hsel = 1'b0;
  logic [11:0]    haddr = 12'h000;
  logic [1:0]     htrans = 2'h0;
  logic           hwrite = 1'b0;
  logic [31:0]    hwdata = 32'h0;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic           hresp;
  mck_events_t    events = '0;
  prog_exc_info_t prog_exc_info = {32'h0000_0c11, 32'h0000_4000, 32'h0000_0006};
  logic           exc_accept, exc_load_done, check_accept, check_load_done, busy;
  logic           check_request, prog_interrupt_request, check_stop, logout_store;
  logic [63:0]    check_cause_code;
  logic [7:0]     hold_cycles = 8'h06;
  logic [31:0]    rd;
  int             err_count = 0;
  int             total_checks = 0;
  int             cycles = 0;
  logic [12:0]    free_ev[4] = '{13'h0002, 13'h0018, 13'h1000, 13'h0800};
  int             free_cc[4] = '{`MCK_CC_W, `MCK_CC_IO_STATUS_TABLER_FAULT, `MCK_CC_SD, `MCK_CC_PD};
  logic [12:0]    rep_ev[5] = '{13'h0200, 13'h0300, 13'h0280, 13'h0010, 13'h0004};
  int             rep_mb[5] = '{`MCK_RM_BIT, `MCK_SM_BIT, `MCK_XM_BIT, `MCK_EM_BIT, `MCK_DM_BIT};
  int             rep_cc[5] = '{`MCK_CC_SR, `MCK_CC_SC, `MCK_CC_OCE, `MCK_CC_ED, `MCK_CC_DG};
  always #4 hclk = ~hclk;
  machine_check_interrupt_control dut_u
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .events(events), .prog_exc_info(prog_exc_info),
    .exc_accept(exc_accept), .exc_load_done(exc_load_done), .check_load_done(check_load_done),
    .check_accept(check_accept), .check_request(check_request), .check_stop(check_stop),
    .prog_interrupt_request(prog_interrupt_request), .check_cause_code(check_cause_code),
    .logout_store(logout_store)
  );
  mck_handler_model handler_u
  (
    .hclk(hclk), .hresetn(hresetn), .check_request(check_request),
    .prog_interrupt_request(prog_interrupt_request), .accept_delay(8'h01),
    .hold_cycles(hold_cycles), .check_accept(check_accept), .check_load_done(check_load_done),
    .exc_accept(exc_accept), .exc_load_done(exc_load_done), .busy(busy)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, exp, rd);
    check("response", 1'b0, hresp);
  endtask
  task automatic pulse(input logic [12:0] m);
    @(posedge hclk);
    events <= mck_events_t'(m);
    @(posedge hclk);
    events <= '0;
    #1;
  endtask
  task automatic wait_req(input logic lvl);
    for (int n = 0; n < 200 && check_request !== lvl; n++)
      @(posedge hclk) #1;
    check("request level", lvl, check_request);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 400 && (busy !== 1'b0 || check_request !== 1'b0); n++)
      @(posedge hclk) #1;
    repeat (4) @(posedge hclk);
  endtask
  task automatic expect_cause(input int b);
    check("request", 1'b1, check_request);
    check("cause bit", 1'b1, check_cause_code[b]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("subclass reset", `MCK_SUBCLASS_OFS, 32'h0);
    rchk("status reset", `MCK_STATUS_OFS, 32'h0);
    bus(1'b1, `MCK_SUBCLASS_OFS, 32'h0000_00ed);
    bus(1'b1, 12'h020, 32'hffff_ffff);
    rchk("subclass rw", `MCK_SUBCLASS_OFS, 32'h0000_00ed);
    rchk("unmapped", 12'h020, 32'h0);
    bus(1'b1, `MCK_SUBCLASS_OFS, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      pulse(free_ev[i]);
      wait_req(1'b1);
      expect_cause(free_cc[i]);
      wait_idle();
    end
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, `MCK_SUBCLASS_OFS, 32'h0000_00ec ^ (32'h1 << rep_mb[i]));
      pulse(rep_ev[i]);
      repeat (3) @(posedge hclk) #1;
      check("held request", 1'b0, check_request);
      bus(1'b1, `MCK_SUBCLASS_OFS, 32'h0000_00ec);
      wait_req(1'b1);
      expect_cause(rep_cc[i]);
      check("delay flag", 1'b0, check_cause_code[`MCK_CC_D]);
      wait_idle();
    end
    bus(1'b1, `MCK_SUBCLASS_OFS, 32'h0);
    hold_cycles <= 8'h28;
    pulse(13'h0002);
    wait_req(1'b1);
    wait_req(1'b0);
    pulse(13'h1000);
    check("deferred", 1'b0, check_request);
    rchk("status deferred", `MCK_STATUS_OFS, 32'h0000_0401);
    wait_req(1'b1);
    expect_cause(`MCK_CC_SD);
    check("delay flag set", 1'b1, check_cause_code[`MCK_CC_D]);
    wait_idle();
    pulse(13'h0001);
    check("direct request", 1'b0, check_request);
    repeat (3) @(posedge hclk);
    pulse(13'h0001);
    expect_cause(`MCK_CC_PEX);
    wait_idle();
    rchk("snap 7", `MCK_SNAP7_OFS, 32'h0000_0c11 ^ 32'h0000_4000);
    rchk("snap 8", `MCK_SNAP8_OFS, 32'h0000_0006);
    repeat (50) @(posedge hclk);
    bus(1'b1, `MCK_SUBCLASS_OFS, 32'h1);
    pulse(13'h0002);
    wait_req(1'b1);
    wait_req(1'b0);
    pulse(13'h1000);
    repeat (2) @(posedge hclk);
    check("check stop", 1'b1, check_stop);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("subclass after reset", `MCK_SUBCLASS_OFS, 32'h0);
    check("stop cleared", 1'b0, check_stop);
    stop_test();
  end
endmodule

// ---- testbench/mck_handler_model.sv ----
// Behavioural interrupt handler that accepts requests and later loads its status word.
// Assumes requests are sampled at rising edges of hclk.
`timescale 1ns/100ps
module mck_handler_model
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       check_request,
  input  wire logic       prog_interrupt_request,
  input  wire logic [7:0] accept_delay,
  input  wire logic [7:0] hold_cycles,
  output logic            check_accept,
  output logic            check_load_done,
  output logic            exc_accept,
  output logic            exc_load_done,
  output logic            busy
);
  // Check handler: accepts after a delay, holds the mask, then loads.
  initial
  begin
    check_accept = 1'b0;
    check_load_done = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge hclk);
      if (hresetn === 1'b1 && check_request === 1'b1)
      begin
        busy <= 1'b1;
        repeat (accept_delay) @(posedge hclk);
        check_accept <= 1'b1;
        @(posedge hclk);
        check_accept <= 1'b0;
        repeat (hold_cycles) @(posedge hclk);
        check_load_done <= 1'b1;
        @(posedge hclk);
        check_load_done <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
  // Program exception handler: accepts at once, loads after the hold time.
  initial
  begin
    exc_accept = 1'b0;
    exc_load_done = 1'b0;
    forever
    begin
      @(posedge hclk);
      if (hresetn === 1'b1 && prog_interrupt_request === 1'b1)
      begin
        exc_accept <= 1'b1;
        @(posedge hclk);
        exc_accept <= 1'b0;
        repeat (hold_cycles) @(posedge hclk);
        exc_load_done <= 1'b1;
        @(posedge hclk);
        exc_load_done <= 1'b0;
      end
    end
  end
endmodule
